/* File: inc/txlvl_pkg.sv */
// Behaviour
// - gen1 full-swing level, bits 4:0, reset 0x11
// - gen1 fine de-emphasis, bits 7:5, reset 0x4
// - gen2 -3.5dB level, bits 12:8, reset 0x17
// - gen2 -3.5dB fine de-emphasis, bits 15:13, reset 0x4
// - gen2 -6.0dB level, bits 20:16, reset 0x13
// - fine de-emphasis ignored in low-swing mode
// - writes reach only the chosen lane
// - all fields software-persistent on every lane
// - low swing when low-swing enable equals 0x1
package txlvl_pkg;

  // ----------------------------------------------------------------------
  // bus and lane geometry
  // ----------------------------------------------------------------------
  localparam int NUM_LANES_DEF = 16;
  localparam int LANE_SEL_W    = 4;
  localparam int ADDR_W        = 8;
  localparam int DATA_W        = 32;
  localparam int FIELDS_W      = 21;

  localparam logic [ADDR_W-1:0] TX_LVL_CTL1_OFS = 8'h00;

  // ----------------------------------------------------------------------
  // field layout and reset values
  // ----------------------------------------------------------------------
  localparam int LVL_G1_LSB   = 0;
  localparam int FINE_G1_LSB  = 5;
  localparam int LVL_G2L_LSB  = 8;
  localparam int FINE_G2L_LSB = 13;
  localparam int LVL_G2H_LSB  = 16;
  localparam int LVL_W        = 5;
  localparam int FINE_W       = 3;

  localparam logic [LVL_W-1:0]  LVL_G1_RST   = 5'h11;
  localparam logic [FINE_W-1:0] FINE_G1_RST  = 3'h4;
  localparam logic [LVL_W-1:0]  LVL_G2L_RST  = 5'h17;
  localparam logic [FINE_W-1:0] FINE_G2L_RST = 3'h4;
  localparam logic [LVL_W-1:0]  LVL_G2H_RST  = 5'h13;

  // port-side encodings
  localparam logic LOW_SWING_ON      = 1'h1;
  localparam logic DEEMPH_SEL_LIGHT  = 1'h1;
  localparam logic RATE_GEN2         = 1'h1;

  // ----------------------------------------------------------------------
  // types
  // ----------------------------------------------------------------------
  // packed so that the bit order matches the register word
  typedef struct packed {
    logic [LVL_W-1:0]  lvl_g2h;
    logic [FINE_W-1:0] fine_g2l;
    logic [LVL_W-1:0]  lvl_g2l;
    logic [FINE_W-1:0] fine_g1;
    logic [LVL_W-1:0]  lvl_g1;
  } lane_fields_t;

  localparam lane_fields_t LANE_FIELDS_RST = '{
    lvl_g2h:  LVL_G2H_RST,
    fine_g2l: FINE_G2L_RST,
    lvl_g2l:  LVL_G2L_RST,
    fine_g1:  FINE_G1_RST,
    lvl_g1:   LVL_G1_RST
  };

  typedef struct packed {
    logic              level_valid;
    logic [LVL_W-1:0]  level;
    logic              fine_valid;
    logic [FINE_W-1:0] fine;
  } drive_setting_t;

  typedef enum logic [1:0] {
    MODE_LOW_SWING   = 2'b00,
    MODE_GEN1        = 2'b01,
    MODE_GEN2_LIGHT  = 2'b10,
    MODE_GEN2_HEAVY  = 2'b11
  } drive_mode_t;

  // ----------------------------------------------------------------------
  // mode decode
  // ----------------------------------------------------------------------
  function automatic drive_mode_t drive_mode(input logic low_swing,
                                             input logic gen2,
                                             input logic deemph_sel);
    drive_mode_t m;
    if (low_swing == LOW_SWING_ON) begin
      m = MODE_LOW_SWING;
    end else if (gen2 != RATE_GEN2) begin
      m = MODE_GEN1;
    end else if (deemph_sel == DEEMPH_SEL_LIGHT) begin
      m = MODE_GEN2_LIGHT;
    end else begin
      m = MODE_GEN2_HEAVY;
    end
    return m;
  endfunction : drive_mode

endpackage : txlvl_pkg

/* File: logic/lane_drive_select.sv */
`timescale 1ns/1ps
module lane_drive_select
  import txlvl_pkg::*;
(
  // clock and reset
  input  wire logic           clk_i,
  input  wire logic           sys_rst_i,
  // stored fields and port state
  input  wire lane_fields_t   fields_i,
  input  wire logic           low_swing_i,
  input  wire logic           gen2_i,
  input  wire logic           deemph_sel_i,
  // analog steering
  output drive_setting_t      setting_o
);

  drive_mode_t    mode;
  drive_setting_t setting_d;
  drive_setting_t setting_q;

  assign mode = drive_mode(low_swing_i, gen2_i, deemph_sel_i);

  // ----------------------------------------------------------------------
  // setting selection
  // ----------------------------------------------------------------------
  always_comb begin
    setting_d = '0;
    case (mode)
      MODE_LOW_SWING: begin
        setting_d = '0;
      end
      MODE_GEN1: begin
        setting_d.level_valid = 1'b1;
        setting_d.level       = fields_i.lvl_g1;
        setting_d.fine_valid  = 1'b1;
        setting_d.fine        = fields_i.fine_g1;
      end
      MODE_GEN2_LIGHT: begin
        setting_d.level_valid = 1'b1;
        setting_d.level       = fields_i.lvl_g2l;
        setting_d.fine_valid  = 1'b1;
        setting_d.fine        = fields_i.fine_g2l;
      end
      MODE_GEN2_HEAVY: begin
        setting_d.level_valid = 1'b1;
        setting_d.level       = fields_i.lvl_g2h;
      end
      default: begin
        setting_d = '0;
      end
    endcase
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      setting_q <= '0;
    end else begin
      setting_q <= setting_d;
    end
  end

  assign setting_o = setting_q;

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  property p_low_swing_no_fine;
    @(posedge clk_i) disable iff (sys_rst_i)
      (low_swing_i == LOW_SWING_ON) |=> !setting_q.fine_valid &&
                                        !setting_q.level_valid;
  endproperty
  a_low_swing_no_fine: assert property (p_low_swing_no_fine)
    else $error("fine de-emphasis active in low swing");

  property p_gen1_pick;
    @(posedge clk_i) disable iff (sys_rst_i)
      (mode == MODE_GEN1) |=> setting_q.level == $past(fields_i.lvl_g1) &&
                              setting_q.fine == $past(fields_i.fine_g1) &&
                              setting_q.level_valid && setting_q.fine_valid;
  endproperty
  a_gen1_pick: assert property (p_gen1_pick)
    else $error("gen1 setting not taken from gen1 fields");

  property p_light_pick;
    @(posedge clk_i) disable iff (sys_rst_i)
      (mode == MODE_GEN2_LIGHT) |=>
        setting_q.level == $past(fields_i.lvl_g2l) &&
        setting_q.fine == $past(fields_i.fine_g2l) && setting_q.fine_valid;
  endproperty
  a_light_pick: assert property (p_light_pick)
    else $error("light de-emphasis setting wrong");

  property p_heavy_pick;
    @(posedge clk_i) disable iff (sys_rst_i)
      (mode == MODE_GEN2_HEAVY) |=>
        setting_q.level == $past(fields_i.lvl_g2h) && setting_q.level_valid &&
        !setting_q.fine_valid;
  endproperty
  a_heavy_pick: assert property (p_heavy_pick)
    else $error("heavy de-emphasis level wrong");

endmodule : lane_drive_select

/* File: logic/serdes_tx_lane_level_control.sv */
`timescale 1ns/1ps
module serdes_tx_lane_level_control
  import txlvl_pkg::*;
#(
  parameter int LANES = NUM_LANES_DEF
)(
  // clock and reset
  input  wire logic                    clk_i,
  input  wire logic                    sys_rst_i,
  // register port
  input  wire logic [ADDR_W-1:0]       addr_i,
  input  wire logic [DATA_W-1:0]       wdata_i,
  input  wire logic                    wr_i,
  input  wire logic                    rd_i,
  output logic      [DATA_W-1:0]       rdata_o,
  // lane choice from the serdes control register
  input  wire logic [LANE_SEL_W-1:0]   lane_choice_i,
  // per-lane port state
  input  wire logic [LANES-1:0]        low_swing_enable_i,
  input  wire logic [LANES-1:0]        gen2_rate_i,
  input  wire logic [LANES-1:0]        deemph_select_i,
  // analog transmitter steering
  output drive_setting_t [LANES-1:0]   setting_o
);

  // ----------------------------------------------------------------------
  // elaboration check
  // ----------------------------------------------------------------------
  if (LANES < 1 || LANES > (1 << LANE_SEL_W)) begin : g_bad_lanes
    $error("LANES must lie between 1 and the lane-choice range");
  end

  // ----------------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------------
  localparam logic [LANE_SEL_W:0] LANES_C = (LANE_SEL_W+1)'(LANES);

  // read word: fields in the low bits, reserved bits zero
  function automatic logic [DATA_W-1:0] pack_word(input lane_fields_t f);
    return {{(DATA_W-FIELDS_W){1'b0}}, f};
  endfunction : pack_word

  // true when the lane choice names lane idx
  function automatic logic picks_lane(input logic [LANE_SEL_W-1:0] c,
                                      input int                    idx);
    return (c == LANE_SEL_W'(idx));
  endfunction : picks_lane

  lane_fields_t              fields_q [LANES];
  logic [DATA_W-1:0]         rdata_d;
  logic [DATA_W-1:0]         rdata_q;
  wire                       addr_hit;
  wire                       lane_ok;
  wire                       wr_hit;
  wire                       rd_hit;
  wire  lane_fields_t        wr_fields;
  wire  lane_fields_t        chosen_fields;

  assign addr_hit  = (addr_i == TX_LVL_CTL1_OFS);
  assign lane_ok   = ({1'b0, lane_choice_i} < LANES_C);
  assign wr_hit    = wr_i && addr_hit && lane_ok;
  assign rd_hit    = rd_i && addr_hit && lane_ok;
  assign wr_fields = lane_fields_t'(wdata_i[FIELDS_W-1:0]);
  assign chosen_fields = lane_ok ? fields_q[lane_choice_i] : LANE_FIELDS_RST;

  // reserved bits and unmapped reads return zero
  assign rdata_d = rd_hit ? pack_word(chosen_fields) : '0;

  // ----------------------------------------------------------------------
  // per-lane field storage
  // ----------------------------------------------------------------------
  for (genvar l = 0; l < LANES; l++) begin : g_lane
    wire lane_wr;
    assign lane_wr = wr_hit && picks_lane(lane_choice_i, l);

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
        fields_q[l] <= LANE_FIELDS_RST;
      end else if (lane_wr) begin
        fields_q[l] <= wr_fields;
      end
    end

    lane_drive_select u_select (
      .clk_i        (clk_i),
      .sys_rst_i    (sys_rst_i),
      .fields_i     (fields_q[l]),
      .low_swing_i  (low_swing_enable_i[l]),
      .gen2_i       (gen2_rate_i[l]),
      .deemph_sel_i (deemph_select_i[l]),
      .setting_o    (setting_o[l])
    );
  end

  // ----------------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign rdata_o = rdata_q;

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  lane_fields_t          prev_q [LANES];
  logic [LANE_SEL_W-1:0] prev_choice_q;
  logic                  prev_wr_q;
  logic                  after_rst_q;
  logic [LANES-1:0]      kept;
  logic [LANES-1:0]      same;

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      prev_choice_q <= '0;
      prev_wr_q     <= 1'b0;
      after_rst_q   <= 1'b1;
    end else begin
      prev_choice_q <= lane_choice_i;
      prev_wr_q     <= wr_hit;
      after_rst_q   <= 1'b0;
    end
  end

  for (genvar k = 0; k < LANES; k++) begin : g_prev
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
        prev_q[k] <= LANE_FIELDS_RST;
      end else begin
        prev_q[k] <= fields_q[k];
      end
    end
    assign same[k] = (fields_q[k] == prev_q[k]);
    assign kept[k] = same[k] || (prev_wr_q && picks_lane(prev_choice_q, k));

    // every lane leaves reset with the documented word
    property p_lane_reset;
      @(posedge clk_i)
        after_rst_q && !sys_rst_i |-> fields_q[k] == LANE_FIELDS_RST;
    endproperty
    a_lane_reset: assert property (p_lane_reset)
      else $error("lane field not at reset value after reset");

    // output moves only when its fields or port state move
    property p_setting_steady;
      @(posedge clk_i) disable iff (sys_rst_i)
        !after_rst_q && same[k] && $stable(low_swing_enable_i[k]) &&
        $stable(gen2_rate_i[k]) && $stable(deemph_select_i[k]) |=>
        $stable(setting_o[k]);
    endproperty
    a_setting_steady: assert property (p_setting_steady)
      else $error("lane setting moved with steady inputs");
  end

  // read of the lane written one cycle before
  sequence s_read_same_lane;
    rd_hit && lane_choice_i == prev_choice_q;
  endsequence

  sequence s_read_req;
    rd_i && addr_hit && lane_ok;
  endsequence

  property p_write_lands;
    lane_fields_t v;
    logic [LANE_SEL_W-1:0] c;
    @(posedge clk_i) disable iff (sys_rst_i)
      (wr_hit, v = wr_fields, c = lane_choice_i) |=> fields_q[c] == v;
  endproperty
  a_write_lands: assert property (p_write_lands)
    else $error("write did not reach chosen lane");

  property p_others_kept;
    @(posedge clk_i) disable iff (sys_rst_i)
      !after_rst_q |-> &kept;
  endproperty
  a_others_kept: assert property (p_others_kept)
    else $error("unchosen lane field changed");

  property p_read_back;
    lane_fields_t v;
    @(posedge clk_i) disable iff (sys_rst_i)
      (s_read_req, v = chosen_fields) |=>
        rdata_o == pack_word(v);
  endproperty
  a_read_back: assert property (p_read_back)
    else $error("read data not the chosen lane word");

  property p_write_then_read;
    lane_fields_t v;
    @(posedge clk_i) disable iff (sys_rst_i)
      (wr_hit, v = wr_fields) ##1 s_read_same_lane |=>
        rdata_o == pack_word(v);
  endproperty
  a_write_then_read: assert property (p_write_then_read)
    else $error("written word not read back");

  property p_idle_zero;
    @(posedge clk_i) disable iff (sys_rst_i)
      !(rd_i && addr_hit && lane_ok) |=> rdata_o == '0;
  endproperty
  a_idle_zero: assert property (p_idle_zero)
    else $error("read data outside read answer");

  property p_reset_values;
    @(posedge clk_i)
      after_rst_q && !sys_rst_i |->
        fields_q[0].lvl_g1 == LVL_G1_RST &&
        fields_q[0].fine_g1 == FINE_G1_RST &&
        fields_q[0].lvl_g2l == LVL_G2L_RST &&
        fields_q[0].fine_g2l == FINE_G2L_RST &&
        fields_q[0].lvl_g2h == LVL_G2H_RST;
  endproperty
  a_reset_values: assert property (p_reset_values)
    else $error("field reset values wrong");

  // a read leaves every stored field alone
  property p_read_keeps;
    @(posedge clk_i) disable iff (sys_rst_i)
      rd_i && !wr_i |=> &same;
  endproperty
  a_read_keeps: assert property (p_read_keeps)
    else $error("read disturbed a lane field");

endmodule : serdes_tx_lane_level_control

/* File: sim/serdes_tx_lane_level_control_bench.sv */
`timescale 1ns/1ps
module serdes_tx_lane_level_control_bench
  import txlvl_pkg::*;
;
  // --------------------------------------------------------------------
  // signals and model state
  // --------------------------------------------------------------------
  localparam int          LANES    = 16;
  localparam logic [31:0] RST_WORD = 32'h0013_9791;

  logic                        clk_i              = 1'b0;
  logic                        sys_rst_i          = 1'b1;
  logic [ADDR_W-1:0]           addr_i             = '0;
  logic [DATA_W-1:0]           wdata_i            = '0;
  logic                        wr_i               = 1'b0;
  logic                        rd_i               = 1'b0;
  logic [DATA_W-1:0]           rdata_o;
  logic [LANE_SEL_W-1:0]       lane_choice_i      = '0;
  logic [LANES-1:0]            low_swing_enable_i = '0;
  logic [LANES-1:0]            gen2_rate_i        = '0;
  logic [LANES-1:0]            deemph_select_i    = '0;
  drive_setting_t [LANES-1:0]  setting_o;
  int                          mdl [LANES];
  int                          n_errors           = 0;
  int                          checks             = 0;
  logic [31:0]                 d;

  always #20 clk_i = ~clk_i;

  serdes_tx_lane_level_control #(.LANES(LANES)) uut (
    .clk_i              (clk_i),
    .sys_rst_i          (sys_rst_i),
    .addr_i             (addr_i),
    .wdata_i            (wdata_i),
    .wr_i               (wr_i),
    .rd_i               (rd_i),
    .rdata_o            (rdata_o),
    .lane_choice_i      (lane_choice_i),
    .low_swing_enable_i (low_swing_enable_i),
    .gen2_rate_i        (gen2_rate_i),
    .deemph_select_i    (deemph_select_i),
    .setting_o          (setting_o)
  );

  // --------------------------------------------------------------------
  // model and compare helpers
  // --------------------------------------------------------------------
  function automatic logic [9:0] exp_set(input int l);
    logic [20:0] f;
    logic [9:0]  s;
    f = mdl[l][20:0];
    if (low_swing_enable_i[l] === 1'b1) s = 10'h000;
    else if (gen2_rate_i[l] !== 1'b1) s = {1'b1, f[4:0], 1'b1, f[7:5]};
    else if (deemph_select_i[l] === 1'b1) s = {1'b1, f[12:8], 1'b1, f[15:13]};
    else s = {1'b1, f[20:16], 4'h0};
    return s;
  endfunction : exp_set

  task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t read got %h exp %h", $time, got, exp);
    end
  endtask : cmp_word

  task automatic cmp_set(input logic [9:0] got, input logic [9:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t setting got %h exp %h", $time, got, exp);
    end
  endtask : cmp_set

  task automatic reg_wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_i);
    addr_i  <= a;
    wdata_i <= v;
    wr_i    <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
    if (a == TX_LVL_CTL1_OFS) mdl[lane_choice_i] = int'(v[20:0]);
  endtask : reg_wr

  task automatic reg_rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    @(negedge clk_i);
    cmp_word(rdata_o, exp); // read back
    @(negedge clk_i);
    cmp_word(rdata_o, 32'h0); // read idle zero
  endtask : reg_rd

  // write strobe followed by a read strobe with no gap
  task automatic reg_wr_rd(input logic [31:0] v);
    @(posedge clk_i);
    addr_i  <= TX_LVL_CTL1_OFS;
    wdata_i <= v;
    wr_i    <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
    rd_i <= 1'b1;
    mdl[lane_choice_i] = int'(v[20:0]);
    @(posedge clk_i);
    rd_i <= 1'b0;
    @(negedge clk_i);
    cmp_word(rdata_o, 32'(mdl[lane_choice_i])); // read after write
  endtask : reg_wr_rd

  task automatic chk_all;
    @(posedge clk_i);
    @(negedge clk_i);
    for (int l = 0; l < LANES; l++) begin
      cmp_set(setting_o[l], exp_set(l)); // steering
    end
  endtask : chk_all

  task automatic port_rand;
    @(posedge clk_i);
    low_swing_enable_i <= 16'($urandom) & 16'($urandom);
    gen2_rate_i        <= 16'($urandom);
    deemph_select_i    <= 16'($urandom);
    chk_all;
  endtask : port_rand

  task automatic test_done;
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : test_done

  // --------------------------------------------------------------------
  // watchdog
  // --------------------------------------------------------------------
  initial begin
    #400000;
    n_errors++;
    $display("BAD %0t watchdog expired", $time);
    test_done;
  end

  // --------------------------------------------------------------------
  // tests
  // --------------------------------------------------------------------
  initial begin
    void'($urandom(32'hCF74));
    for (int l = 0; l < LANES; l++) mdl[l] = int'(RST_WORD);
    repeat (8) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    chk_all; // reset steering
    for (int l = 0; l < LANES; l++) begin
      @(posedge clk_i);
      lane_choice_i <= 4'(l);
      reg_rd(TX_LVL_CTL1_OFS, RST_WORD); // reset word
    end
    $display("test reset_values done");

    repeat (24) port_rand; // mode decode
    $display("test port_modes done");

    repeat (40) begin
      @(posedge clk_i);
      lane_choice_i <= 4'($urandom);
      d = $urandom;
      reg_wr(TX_LVL_CTL1_OFS, d); // chosen lane only
      chk_all; // other lanes kept
      reg_rd(TX_LVL_CTL1_OFS, mdl[lane_choice_i]); // lane read
      port_rand; // new fields steer
    end
    $display("test lane_writes done");

    repeat (8) begin
      @(posedge clk_i);
      lane_choice_i <= 4'($urandom);
      d = $urandom;
      d[7:5] = FINE_G1_RST;
      reg_wr_rd(d); // nominal gen1 de-emphasis, back to back
    end
    chk_all; // steering of all lanes, in the last random port modes, after back-to-back writes
    $display("test back_to_back done");

    repeat (8) begin
      d = $urandom;
      reg_wr(8'($urandom) | 8'h01, d); // unmapped write ignored
      reg_rd(8'($urandom) | 8'h01, 32'h0); // unmapped read zero
      reg_rd(TX_LVL_CTL1_OFS, mdl[lane_choice_i]); // unchanged
    end
    chk_all; // all lanes kept
    $display("test unmapped done");

    @(posedge clk_i);
    sys_rst_i <= 1'b1;
    @(negedge clk_i);
    for (int l = 0; l < LANES; l++) begin
      cmp_set(setting_o[l], 10'h000); // outputs clear in reset
      mdl[l] = int'(RST_WORD);
    end
    @(posedge clk_i);
    sys_rst_i <= 1'b0;
    chk_all; // fields back to reset
    reg_rd(TX_LVL_CTL1_OFS, RST_WORD); // chosen lane word back to reset value
    $display("test mid_reset done");
    test_done;
  end

endmodule : serdes_tx_lane_level_control_bench
